/* hw/mie_pkg.sv */
/*
 * Shared constants and types for the 8-bit core's decode and execute logic:
 * opcode field layout, instruction and ALU operation enumerations, widths and
 * reset values.
 * Assumes nothing of its surroundings; imported whole by every design module.
 */
package mie_pkg;

    localparam int PC_W = 12;
    localparam int DATA_W = 8;
    localparam int OP_W = 16;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;

    // opcode field positions
    localparam int GRP_MSB = 15;
    localparam int GRP_LSB = 14;
    localparam int REG_OP_MSB = 13;
    localparam int REG_OP_LSB = 9;
    localparam int DEST_POS = 8;
    localparam int BIT_OP_MSB = 13;
    localparam int BIT_OP_LSB = 12;
    localparam int BIT_SEL_MSB = 10;
    localparam int BIT_SEL_LSB = 8;
    localparam int JMP_OP_MSB = 13;
    localparam int JMP_OP_LSB = 12;
    localparam int LIT_OP_MSB = 13;
    localparam int LIT_OP_LSB = 8;
    localparam int ADDR_MSB = 7;
    localparam int TARGET_MSB = 11;

    localparam logic [1:0] GRP_REG = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;

    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_MEM = 1'h1;

    // sizes of each opcode group and where each starts in the enumeration
    localparam int INSTR_COUNT = 37;
    localparam int REG_OPS = 17;
    localparam int BIT_OPS = 4;
    localparam int JMP_OPS = 2;
    localparam int LIT_OPS = 14;
    localparam int REG_BASE = 0;
    localparam int BIT_BASE = REG_BASE + REG_OPS;
    localparam int JMP_BASE = BIT_BASE + BIT_OPS;
    localparam int LIT_BASE = JMP_BASE + JMP_OPS;

    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic [DATA_W-1:0] REL_JUMP_NEG_THRESHOLD = 8'h80;

    typedef enum logic [5:0] {
        I_ADD_REG_TO_MEM, I_ADD_WITH_CARRY_OP, I_SUBTRACT_REG_OP, I_SUB_BORROW_REG,
        I_AND_REG_OP, I_OR_REG_OP, I_XOR_REG_OP, I_DECREMENT_OP, I_INCREMENT_OP,
        I_DECREMENT_SKIP_ZERO, I_INCREMENT_SKIP_ZERO, I_INVERT_REG, I_ROTATE_LEFT,
        I_ROTATE_RIGHT, I_LOAD_ACC, I_STORE_ACC, I_CLEAR_REG,
        I_BIT_CLEAR, I_BIT_SET, I_TEST_SKIP_CLEAR, I_TEST_SKIP_SET,
        I_SUB_CALL, I_JUMP_ABS,
        I_ADD_LIT, I_AND_LIT, I_OR_LIT, I_XOR_LIT, I_LOAD_LIT, I_SUB_LIT, I_RETURN_LIT,
        I_RELATIVE_JUMP_OP, I_WATCHDOG_CLEAR_OP, I_HALT, I_SLEEP, I_NOP,
        I_INTERRUPT_RETURN_OP, I_RETURN, I_ILLEGAL
    } mie_instr_type;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBC, ALU_AND, ALU_OR, ALU_XOR,
        ALU_DEC, ALU_INC, ALU_COM, ALU_RL, ALU_RR, ALU_PASS
    } mie_alu_type;

    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_SLEEP} mie_state_type;

endpackage

/* hw/mie_alu.sv */
/*
 * Combinational 8-bit ALU of the core: add, add with carry, subtract,
 * logic, increment, decrement, invert and rotate through carry.
 * Assumes the caller registers the results; a is the memory operand or
 * literal, b the accumulator.
 */
`timescale 1ns/100ps
`default_nettype none

module mie_alu
    import mie_pkg::*;
(
    input wire mie_alu_type op,
    input wire logic [DATA_W-1:0] a,
    input wire logic [DATA_W-1:0] b,
    input wire logic cin,
    output logic [DATA_W-1:0] res,
    output logic c_out,
    output logic nib_out,
    output logic z_out
);

    logic [DATA_W-1:0] bop;
    logic cy;
    logic [DATA_W:0] sum;
    logic [4:0] nib;

    always_comb begin
        bop = b;
        cy = 1'b0;
        sum = 9'h000;
        nib = 5'h00;
        res = a;
        c_out = cin;
        nib_out = 1'b0;
        case (op)
            ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBC: begin
                // subtract is a plus inverted b; carry out means no borrow
                if (op == ALU_SUB || op == ALU_SUBC) begin
                    bop = ~b;
                end
                if (op == ALU_SUB) begin
                    cy = 1'b1;
                end else if (op == ALU_ADD) begin
                    cy = 1'b0;
                end else begin
                    cy = cin;
                end
                sum = {1'b0, a} + {1'b0, bop} + {8'h00, cy};
                nib = {1'b0, a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cy};
                res = sum[DATA_W-1:0];
                c_out = sum[DATA_W];
                nib_out = nib[4];
            end
            ALU_AND: res = a & b;
            ALU_OR: res = a | b;
            ALU_XOR: res = a ^ b;
            ALU_DEC: res = a - 8'h01;
            ALU_INC: res = a + 8'h01;
            ALU_COM: res = ~a;
            ALU_RL: begin
                res = {a[6:0], cin};
                c_out = a[7];
            end
            ALU_RR: begin
                res = {cin, a[7:1]};
                c_out = a[0];
            end
            default: res = a;
        endcase
        z_out = (res == 8'h00);
    end

endmodule

`default_nettype wire

/* hw/mie_core.sv */
/*
 * Decode and execute core of a small 8-bit controller: 37 instructions in
 * 16-bit opcodes, accumulator plus data memory, return stack, halt and sleep.
 * Assumes program memory and data memory answer combinationally to the
 * addresses this block drives from flip-flops; interrupt inputs are async.
 */
// How it works
// - all 37 instructions decoded from one 16-bit opcode word each
// - destination bit low writes accumulator, high writes the memory location, except load, store and clear, which ignore it
// - register add: memory plus accumulator, one cycle, carry nibble-carry zero
// - add with carry: memory plus accumulator plus carry, one cycle, three flags
// - register subtract: memory minus accumulator, one cycle, three flags
// - register and, one cycle, only zero flag changes
// - register or, one cycle, only zero flag changes
// - register xor, one cycle, only zero flag changes
// - decrement memory operand, one cycle, zero flag updated
// - increment memory operand, one cycle, zero flag updated
// - decrement and skip next on zero, one or two cycles, no flags
// - increment and skip next on zero, one or two cycles, no flags
// - call pushes next address and loads literal target, two cycles
// - relative jump loads pc plus one plus accumulator, two cycles, no flags
// - accumulator at or above threshold counts negative, jump goes backward
// - watchdog clear pulses counter reset in one cycle, clears power-down flag, other flags untouched
// - halt freezes pc and fetching until any interrupt, then resumes
// - sleep stops oscillators, sets power-down flag, wakes on external irq
`timescale 1ns/100ps
`default_nettype none

module mie_core
    import mie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [OP_W-1:0] prog_data,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic irq_req,
    input wire logic ext_irq,
    output logic [PC_W-1:0] prog_addr,
    output logic [DATA_W-1:0] mem_raddr,
    output logic [DATA_W-1:0] mem_waddr,
    output logic [DATA_W-1:0] mem_wdata,
    output logic mem_we,
    output logic [DATA_W-1:0] acc_out,
    output logic carry_flag,
    output logic nibble_carry_flag,
    output logic zero_flag,
    output logic sleep_entry_flag,
    output logic global_irq_enable,
    output logic wdt_clear,
    output logic osc_stop,
    output logic cpu_halted
);

    function automatic mie_instr_type decode_instr(input logic [OP_W-1:0] op);
        mie_instr_type k;
        k = I_ILLEGAL;
        case (op[GRP_MSB:GRP_LSB])
            GRP_REG: begin
                if (int'(op[REG_OP_MSB:REG_OP_LSB]) < REG_OPS) begin
                    k = mie_instr_type'(REG_BASE + int'(op[REG_OP_MSB:REG_OP_LSB]));
                end
            end
            GRP_BIT: k = mie_instr_type'(BIT_BASE + int'(op[BIT_OP_MSB:BIT_OP_LSB]));
            GRP_JMP: begin
                if (int'(op[JMP_OP_MSB:JMP_OP_LSB]) < JMP_OPS) begin
                    k = mie_instr_type'(JMP_BASE + int'(op[JMP_OP_MSB:JMP_OP_LSB]));
                end
            end
            default: begin
                if (int'(op[LIT_OP_MSB:LIT_OP_LSB]) < LIT_OPS) begin
                    k = mie_instr_type'(LIT_BASE + int'(op[LIT_OP_MSB:LIT_OP_LSB]));
                end
            end
        endcase
        return k;
    endfunction

    mie_state_type state_reg, state_next;
    logic [PC_W-1:0] pc_reg;
    logic [OP_W-1:0] ir_reg;
    logic ir_valid_reg;
    logic [DATA_W-1:0] w_reg;
    logic carry_reg, nib_reg, zero_reg, sleep_flag_reg, irq_en_reg;
    logic mem_we_reg, wdt_clear_reg, osc_stop_reg, halted_reg;
    logic [DATA_W-1:0] mem_waddr_reg, mem_wdata_reg;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [STACK_PTR_W-1:0] sp_reg;
    logic [1:0] irq_meta, irq_sync;

    mie_instr_type kind;
    mie_alu_type alu_op;
    logic exec, d_mem, wake_halt;
    logic [DATA_W-1:0] f_addr, lit, operand, alu_a, alu_res;
    logic [2:0] bit_sel;
    logic alu_c, alu_nib, alu_z;
    logic [DATA_W-1:0] w_next, wr_data;
    logic c_next, nib_next, z_next, irq_en_next;
    logic wr_en, skip, jump, push, pop, to_halt, to_sleep, wdt_req;
    logic [PC_W-1:0] target, stack_top, rel_ofs;

    assign exec = ir_valid_reg && (state_reg == ST_RUN);
    assign kind = decode_instr(ir_reg);
    assign f_addr = ir_reg[ADDR_MSB:0];
    assign lit = ir_reg[ADDR_MSB:0];
    assign d_mem = ir_reg[DEST_POS];
    assign bit_sel = ir_reg[BIT_SEL_MSB:BIT_SEL_LSB];
    // a write still in flight to the same address is forwarded
    assign operand = (mem_we_reg && mem_waddr_reg == f_addr) ? mem_wdata_reg : mem_rdata;
    assign stack_top = stack_mem[sp_reg - 3'h1];
    assign wake_halt = irq_sync[0] || irq_sync[1];
    assign rel_ofs = (w_reg >= REL_JUMP_NEG_THRESHOLD) ? {4'hf, w_reg} : {4'h0, w_reg};

    always_comb begin
        alu_op = ALU_PASS;
        alu_a = operand;
        case (kind)
            I_ADD_REG_TO_MEM: alu_op = ALU_ADD;
            I_ADD_WITH_CARRY_OP: alu_op = ALU_ADDC;
            I_SUBTRACT_REG_OP: alu_op = ALU_SUB;
            I_SUB_BORROW_REG: alu_op = ALU_SUBC;
            I_AND_REG_OP: alu_op = ALU_AND;
            I_OR_REG_OP: alu_op = ALU_OR;
            I_XOR_REG_OP: alu_op = ALU_XOR;
            I_DECREMENT_OP, I_DECREMENT_SKIP_ZERO: alu_op = ALU_DEC;
            I_INCREMENT_OP, I_INCREMENT_SKIP_ZERO: alu_op = ALU_INC;
            I_INVERT_REG: alu_op = ALU_COM;
            I_ROTATE_LEFT: alu_op = ALU_RL;
            I_ROTATE_RIGHT: alu_op = ALU_RR;
            default: alu_op = ALU_PASS;
        endcase
        case (kind)
            I_ADD_LIT: alu_op = ALU_ADD;
            I_SUB_LIT: alu_op = ALU_SUB;
            I_AND_LIT: alu_op = ALU_AND;
            I_OR_LIT: alu_op = ALU_OR;
            I_XOR_LIT: alu_op = ALU_XOR;
            default: alu_op = alu_op;
        endcase
        if (ir_reg[GRP_MSB:GRP_LSB] == GRP_LIT) begin
            alu_a = lit;
        end
    end

    mie_alu mie_alu_inst (
        .op(alu_op),
        .a(alu_a),
        .b(w_reg),
        .cin(carry_reg),
        .res(alu_res),
        .c_out(alu_c),
        .nib_out(alu_nib),
        .z_out(alu_z)
    );

    always_comb begin
        w_next = w_reg;
        c_next = carry_reg;
        nib_next = nib_reg;
        z_next = zero_reg;
        irq_en_next = irq_en_reg;
        wr_en = 1'b0;
        wr_data = alu_res;
        skip = 1'b0;
        jump = 1'b0;
        target = pc_reg;
        push = 1'b0;
        pop = 1'b0;
        to_halt = 1'b0;
        to_sleep = 1'b0;
        wdt_req = 1'b0;
        case (kind)
            I_ADD_REG_TO_MEM, I_ADD_WITH_CARRY_OP, I_SUBTRACT_REG_OP, I_SUB_BORROW_REG,
            I_AND_REG_OP, I_OR_REG_OP, I_XOR_REG_OP, I_DECREMENT_OP, I_INCREMENT_OP,
            I_INVERT_REG, I_ROTATE_LEFT, I_ROTATE_RIGHT,
            I_DECREMENT_SKIP_ZERO, I_INCREMENT_SKIP_ZERO: begin
                if (d_mem == DEST_MEM) begin
                    wr_en = 1'b1;
                end else begin
                    w_next = alu_res;
                end
                if (kind inside {I_ADD_REG_TO_MEM, I_ADD_WITH_CARRY_OP,
                                 I_SUBTRACT_REG_OP, I_SUB_BORROW_REG}) begin
                    c_next = alu_c;
                    nib_next = alu_nib;
                end
                if (kind inside {I_ROTATE_LEFT, I_ROTATE_RIGHT}) begin
                    c_next = alu_c;
                end
                if (kind inside {I_DECREMENT_SKIP_ZERO, I_INCREMENT_SKIP_ZERO}) begin
                    skip = alu_z;
                end else begin
                    z_next = alu_z;
                end
            end
            I_LOAD_ACC: w_next = operand;
            I_STORE_ACC: begin
                wr_en = 1'b1;
                wr_data = w_reg;
            end
            I_CLEAR_REG: begin
                wr_en = 1'b1;
                wr_data = 8'h00;
                z_next = 1'b1;
            end
            I_BIT_CLEAR, I_BIT_SET: begin
                wr_en = 1'b1;
                wr_data = operand;
                wr_data[bit_sel] = (kind == I_BIT_SET);
            end
            I_TEST_SKIP_CLEAR: skip = !operand[bit_sel];
            I_TEST_SKIP_SET: skip = operand[bit_sel];
            I_SUB_CALL: begin
                push = 1'b1;
                jump = 1'b1;
                target = ir_reg[TARGET_MSB:0];
            end
            I_JUMP_ABS: begin
                jump = 1'b1;
                target = ir_reg[TARGET_MSB:0];
            end
            I_ADD_LIT, I_SUB_LIT: begin
                w_next = alu_res;
                c_next = alu_c;
                nib_next = alu_nib;
                z_next = alu_z;
            end
            I_AND_LIT, I_OR_LIT, I_XOR_LIT: begin
                w_next = alu_res;
                z_next = alu_z;
            end
            I_LOAD_LIT: w_next = lit;
            I_RETURN_LIT, I_RETURN, I_INTERRUPT_RETURN_OP: begin
                pop = 1'b1;
                jump = 1'b1;
                target = stack_top;
                if (kind == I_RETURN_LIT) begin
                    w_next = lit;
                end
                if (kind == I_INTERRUPT_RETURN_OP) begin
                    irq_en_next = 1'b1;
                end
            end
            I_RELATIVE_JUMP_OP: begin
                jump = 1'b1;
                target = pc_reg + rel_ofs;
            end
            I_WATCHDOG_CLEAR_OP: wdt_req = 1'b1;
            I_HALT: to_halt = 1'b1;
            I_SLEEP: to_sleep = 1'b1;
            default: w_next = w_reg;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (exec && to_halt) begin
                    state_next = ST_HALT;
                end else if (exec && to_sleep) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_HALT: begin
                if (wake_halt) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                if (irq_sync[1]) begin
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    // interrupt inputs: bit 0 internal request, bit 1 external pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_meta <= 2'h0;
            irq_sync <= 2'h0;
        end else begin
            irq_meta <= {ext_irq, irq_req};
            irq_sync <= irq_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            osc_stop_reg <= 1'b0;
            halted_reg <= 1'b0;
            pc_reg <= PC_RESET;
            ir_reg <= 16'h0000;
            ir_valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            osc_stop_reg <= (state_next == ST_SLEEP);
            halted_reg <= (state_next == ST_HALT);
            if (state_reg == ST_RUN) begin
                ir_reg <= prog_data;
                if (exec && jump) begin
                    pc_reg <= target;
                end else if (!(exec && (to_halt || to_sleep))) begin
                    pc_reg <= pc_reg + 12'h001;
                end
                // the slot behind a taken branch or skip is discarded
                ir_valid_reg <= !(exec && (jump || skip || to_halt || to_sleep));
            end else begin
                ir_valid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_reg <= ACC_RESET;
            carry_reg <= FLAG_RESET;
            nib_reg <= FLAG_RESET;
            zero_reg <= FLAG_RESET;
            irq_en_reg <= FLAG_RESET;
            mem_we_reg <= 1'b0;
            mem_waddr_reg <= 8'h00;
            mem_wdata_reg <= 8'h00;
            wdt_clear_reg <= 1'b0;
            sleep_flag_reg <= FLAG_RESET;
        end else begin
            mem_we_reg <= exec && wr_en;
            wdt_clear_reg <= exec && wdt_req;
            if (exec) begin
                w_reg <= w_next;
                carry_reg <= c_next;
                nib_reg <= nib_next;
                zero_reg <= z_next;
                irq_en_reg <= irq_en_next;
                mem_waddr_reg <= f_addr;
                mem_wdata_reg <= wr_data;
            end
            if (exec && to_sleep) begin
                sleep_flag_reg <= 1'b1;
            end else if (exec && wdt_req) begin
                sleep_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= 3'h0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= PC_RESET;
            end
        end else if (exec && push) begin
            stack_mem[sp_reg] <= pc_reg;
            sp_reg <= sp_reg + 3'h1;
        end else if (exec && pop) begin
            sp_reg <= sp_reg - 3'h1;
        end
    end

    assign prog_addr = pc_reg;
    assign mem_raddr = ir_reg[ADDR_MSB:0];
    assign mem_waddr = mem_waddr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign mem_we = mem_we_reg;
    assign acc_out = w_reg;
    assign carry_flag = carry_reg;
    assign nibble_carry_flag = nib_reg;
    assign zero_flag = zero_reg;
    assign sleep_entry_flag = sleep_flag_reg;
    assign global_irq_enable = irq_en_reg;
    assign wdt_clear = wdt_clear_reg;
    assign osc_stop = osc_stop_reg;
    assign cpu_halted = halted_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_add_sum: assert property (exec && kind == I_ADD_REG_TO_MEM && !d_mem |=>
        w_reg == 8'($past(operand) + $past(w_reg)) && !mem_we_reg)
        else $error("add result wrong");
    a_addc_sum: assert property (exec && kind == I_ADD_WITH_CARRY_OP && !d_mem |=>
        {carry_reg, w_reg} == {1'b0, $past(operand)} + {1'b0, $past(w_reg)}
        + {8'h00, $past(carry_reg)})
        else $error("add with carry wrong");
    a_sub_diff: assert property (exec && kind == I_SUBTRACT_REG_OP && !d_mem |=>
        w_reg == 8'($past(operand) - $past(w_reg)))
        else $error("subtract result wrong");
    a_logic_flags: assert property (exec && kind inside {I_AND_REG_OP, I_OR_REG_OP,
        I_XOR_REG_OP} |=> $stable(carry_reg) && $stable(nib_reg)
        && zero_reg == (8'h00 == ($past(kind) == I_AND_REG_OP ? $past(operand & w_reg)
        : $past(kind) == I_OR_REG_OP ? $past(operand | w_reg) : $past(operand ^ w_reg))))
        else $error("logic op flags wrong");
    a_dest_mem: assert property (exec && kind == I_INCREMENT_OP && d_mem |=>
        mem_we_reg && mem_waddr_reg == $past(f_addr)
        && mem_wdata_reg == 8'($past(operand) + 8'h01) && $stable(w_reg))
        else $error("memory destination wrong");
    a_skip_slot: assert property (exec && kind inside {I_DECREMENT_SKIP_ZERO,
        I_INCREMENT_SKIP_ZERO} && alu_z |=> !ir_valid_reg && $stable(zero_reg)
        && $stable(carry_reg) ##1 ir_valid_reg)
        else $error("skip slot not discarded");
    a_call_push: assert property (exec && kind == I_SUB_CALL |=>
        pc_reg == $past(ir_reg[TARGET_MSB:0]) && stack_top == $past(pc_reg)
        && !ir_valid_reg)
        else $error("call push wrong");
    a_rel_jump: assert property (exec && kind == I_RELATIVE_JUMP_OP |=>
        pc_reg == 12'($past(pc_reg) + {{4{$past(w_reg[7])}}, $past(w_reg)})
        && $stable(zero_reg) && !ir_valid_reg)
        else $error("relative jump target wrong");
    a_wdt_pulse: assert property (exec && kind == I_WATCHDOG_CLEAR_OP |=>
        wdt_clear_reg && $stable(carry_reg) && $stable(zero_reg) ##1 !wdt_clear_reg)
        else $error("watchdog clear pulse wrong");
    a_halt_freeze: assert property (state_reg == ST_HALT && !wake_halt |=>
        $stable(pc_reg) && !ir_valid_reg && cpu_halted)
        else $error("halt did not freeze");
    a_sleep_entry: assert property (exec && kind == I_SLEEP |=>
        sleep_entry_flag && osc_stop_reg && state_reg == ST_SLEEP)
        else $error("sleep entry wrong");
    a_int_return: assert property (exec && kind == I_INTERRUPT_RETURN_OP |=>
        irq_en_reg && pc_reg == $past(stack_top) && !ir_valid_reg)
        else $error("interrupt return wrong");

endmodule

`default_nettype wire

/* testbench/mie_mem_model.sv */
/*
 * Program and data memory beside the core.
 * Assumes combinational reads and a write on each rising clock edge with mem_we high.
 */
`timescale 1ns/100ps
`default_nettype none

module mie_mem_model
    import mie_pkg::*;
(
    input wire logic clk,
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [DATA_W-1:0] mem_raddr,
    input wire logic [DATA_W-1:0] mem_waddr,
    input wire logic [DATA_W-1:0] mem_wdata,
    input wire logic mem_we,
    output logic [OP_W-1:0] prog_data,
    output logic [DATA_W-1:0] mem_rdata
);
    logic [OP_W-1:0] rom [0:2**PC_W-1];
    logic [DATA_W-1:0] ram [0:255];
    assign prog_data = rom[prog_addr];
    assign mem_rdata = ram[mem_raddr];
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            ram[mem_waddr] <= mem_wdata;
        end
    end
endmodule

`default_nettype wire

/* testbench/mie_core_tb_top.sv */
/*
 * Self-checking bench: each task loads a program, resets, runs, checks.
 * Assumes the memory model answers combinationally.
 */
`timescale 1ns/100ps
`default_nettype none

module mie_core_tb_top;
    import mie_pkg::*;
    logic clk = 0, rst_n = 0, irq_req = 0, ext_irq = 0;
    logic [OP_W-1:0] prog_data;
    logic [DATA_W-1:0] mem_rdata, mem_raddr, mem_waddr, mem_wdata, acc_out;
    logic [PC_W-1:0] prog_addr;
    logic mem_we, carry_flag, nibble_carry_flag, zero_flag, sleep_entry_flag;
    logic global_irq_enable, wdt_clear, osc_stop, cpu_halted;
    int bad_count = 0, n_compared = 0, wdt_seen = 0;
    always #50 clk = ~clk;
    always @(negedge clk) if (wdt_clear === 1'b1) wdt_seen++;
    mie_core mie_core_inst (.clk(clk), .rst_n(rst_n), .prog_data(prog_data),
        .mem_rdata(mem_rdata), .irq_req(irq_req), .ext_irq(ext_irq), .prog_addr(prog_addr),
        .mem_raddr(mem_raddr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .acc_out(acc_out), .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
        .zero_flag(zero_flag), .sleep_entry_flag(sleep_entry_flag),
        .global_irq_enable(global_irq_enable), .wdt_clear(wdt_clear), .osc_stop(osc_stop),
        .cpu_halted(cpu_halted));
    mie_mem_model mie_mem_model_inst (.clk(clk), .prog_addr(prog_addr), .mem_raddr(mem_raddr),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .prog_data(prog_data), .mem_rdata(mem_rdata));
    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    // reset held while the program is loaded; unused slots are no-operations
    task prep();
        @(negedge clk);
        rst_n = 0;
        wdt_seen = 0;
        for (int i = 0; i < 2**PC_W; i++) mie_mem_model_inst.rom[i] = 16'hcb00;
        for (int i = 0; i < 256; i++) mie_mem_model_inst.ram[i] = 8'h00;
    endtask
    task go(input int n);
        repeat (2) @(negedge clk);
        rst_n = 1;
        repeat (n) @(negedge clk);
    endtask
    task t_arith();
        prep();
        mie_mem_model_inst.ram[8'h10] = 8'hc2;
        mie_mem_model_inst.ram[8'h12] = 8'hda;
        mie_mem_model_inst.rom[0] = 16'hc417;
        mie_mem_model_inst.rom[1] = 16'h0010;
        mie_mem_model_inst.rom[2] = 16'h0110;
        mie_mem_model_inst.rom[3] = 16'h0211;
        mie_mem_model_inst.rom[4] = 16'h0412;
        go(10);
        chk(mie_mem_model_inst.ram[8'h10] === 8'h9b, "add to memory");
        chk(acc_out === 8'h00 && zero_flag === 1'b1, "sub result");
        chk(carry_flag === 1'b1 && nibble_carry_flag === 1'b1, "sub no borrow");
    endtask
    task t_logic();
        prep();
        mie_mem_model_inst.ram[8'h13] = 8'h3c;
        mie_mem_model_inst.ram[8'h14] = 8'h01;
        mie_mem_model_inst.rom[0] = 16'hc4f0;
        mie_mem_model_inst.rom[1] = 16'h0813;
        mie_mem_model_inst.rom[2] = 16'h0a13;
        mie_mem_model_inst.rom[3] = 16'h0d13;
        mie_mem_model_inst.rom[4] = 16'h0e14;
        mie_mem_model_inst.rom[5] = 16'h1114;
        go(10);
        chk(mie_mem_model_inst.ram[8'h13] === 8'h00, "and or xor");
        chk(acc_out === 8'h00, "decrement");
        chk(mie_mem_model_inst.ram[8'h14] === 8'h02 && zero_flag === 1'b0, "inc");
    endtask
    task t_skip();
        prep();
        mie_mem_model_inst.ram[8'h15] = 8'h01;
        mie_mem_model_inst.ram[8'h16] = 8'hff;
        mie_mem_model_inst.rom[0] = 16'h1315;
        mie_mem_model_inst.rom[1] = 16'hc455;
        mie_mem_model_inst.rom[2] = 16'h1516;
        mie_mem_model_inst.rom[3] = 16'hc477;
        go(10);
        chk(acc_out === 8'h00 && zero_flag === 1'b0, "skips");
        chk(mie_mem_model_inst.ram[8'h15] === 8'h00, "dec skip store");
        chk(mie_mem_model_inst.ram[8'h16] === 8'h00, "inc skip store");
    endtask
    task t_jump();
        prep();
        mie_mem_model_inst.rom[0] = 16'h8210;
        mie_mem_model_inst.rom[1] = 16'hc45a;
        mie_mem_model_inst.rom[12'h210] = 16'hc480;
        mie_mem_model_inst.rom[12'h211] = 16'hc700;
        mie_mem_model_inst.rom[12'h192] = 16'hcc00;
        go(20);
        chk(acc_out === 8'h5a, "call, back jump, return");
        chk(global_irq_enable === 1'b1, "irq enable set");
    endtask
    task t_power();
        prep();
        mie_mem_model_inst.rom[0] = 16'hc800;
        mie_mem_model_inst.rom[1] = 16'hc900;
        mie_mem_model_inst.rom[2] = 16'hc433;
        mie_mem_model_inst.rom[3] = 16'hca00;
        mie_mem_model_inst.rom[4] = 16'hc444;
        go(8);
        chk(wdt_seen == 1, "watchdog pulse");
        chk(cpu_halted === 1'b1 && acc_out === 8'h00, "halted");
        irq_req = 1;
        repeat (12) @(negedge clk);
        chk(cpu_halted === 1'b0 && acc_out === 8'h33, "halt wake");
        chk(osc_stop === 1'b1 && sleep_entry_flag === 1'b1, "asleep");
        irq_req = 0;
        ext_irq = 1;
        repeat (12) @(negedge clk);
        chk(osc_stop === 1'b0 && acc_out === 8'h44, "sleep wake");
        ext_irq = 0;
    endtask
    task final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1ms;
        bad_count++;
        final_report();
    end
    initial begin
        t_arith();
        t_logic();
        t_skip();
        t_jump();
        t_power();
        final_report();
    end
endmodule

`default_nettype wire
